// ===== dv/bf_partner.sv
// Primary protection stage: closes its trip contact lat_i ticks after fault.
// Assumes the bench drives tick and fault levels.
`default_nettype none
module bf_partner (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic fault_i,
  input wire logic [3:0] lat_i,
  output logic trip_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] n_ff;
  // Count fault ticks, open on the first tick that sees the fault cleared
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      n_ff <= 4'h0;
      trip_o <= 1'b0;
    end else if (tick_i) begin
      n_ff <= (fault_i && n_ff != lat_i) ? n_ff + 4'h1 : n_ff & {4{fault_i}};
      trip_o <= fault_i && n_ff == lat_i;
    end
  end
endmodule : bf_partner
`default_nettype wire

// ===== dv/bf_timer_monitor.sv
// Port checker of the breaker failure supervision block.
// Assumes one core clock and an active-low asynchronous reset.
`default_nettype none
module bf_timer_monitor
  import bf_timer_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic cycle_tick_i,
  input wire currents_t currents_i,
  input wire logic primary_trip_i,
  input wire logic block_i,
  input wire op_mode_t mode_i,
  input wire logic retrip_enable_i,
  input wire logic start_o,
  input wire logic blocked_o,
  input wire logic redundant_trip_o,
  input wire logic breaker_failure_trip_o,
  input wire bf_status_t status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic ev = clk_en_i && cycle_tick_i;
  wire logic rt = redundant_trip_o;
  wire logic ft = breaker_failure_trip_o;
  blk_no_trip_a: assert property (blocked_o |-> !rt && !ft)
    else $error("trip while blocked");
  retrip_off_a: assert property (ev && !retrip_enable_i |=> !rt)
    else $error("retrip while disabled");
  start_excl_a: assert property (!(start_o && blocked_o))
    else $error("start and blocked together");
  block_drop_a: assert property (ev && block_i |=> !start_o && !ft)
    else $error("start kept under blocking");
  cur_drop_a: assert property (
    ev && mode_i == MODE_CURRENT && currents_i == '0 |=> !start_o && !rt)
    else $error("no release on current drop");
  contact_halt_a: assert property (
    ev && mode_i == MODE_CUR_AND_CONTACT && !primary_trip_i |=> !rt && !ft)
    else $error("trip without contact");
  hold_quiet_a: assert property (!ev |=> $stable(status_o))
    else $error("status moved without tick");
  status_map_a: assert property (status_o == (blocked_o ? ST_BLOCKED :
    ft ? ST_FAIL_ON : rt ? ST_RETRIP : start_o ? ST_START : ST_NORMAL))
    else $error("status disagrees with outputs");
  fail_start_a: assert property ($rose(ft) |-> start_o)
    else $error("failure trip without start");
  cover property (ft);
  cover property (rt);
  cover property (blocked_o);
endmodule : bf_timer_monitor
bind breaker_failure_timer_logic bf_timer_monitor i_bf_timer_monitor (
  .core_clk_i, .resetn_i, .clk_en_i, .cycle_tick_i, .currents_i,
  .primary_trip_i, .block_i, .mode_i, .retrip_enable_i, .start_o,
  .blocked_o, .redundant_trip_o, .breaker_failure_trip_o, .status_o);
`default_nettype wire

// ===== dv/breaker_failure_timer_logic_test.sv
// Bench: reference model against the supervision block every cycle.
// Assumes bf_partner plays the primary protection stage.
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0d got %0d", n, e, a); end end
module breaker_failure_timer_logic_test import bf_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, tick = 1'b0, rte = 1'b1;
  logic blk = 1'b0, flt = 1'b0, trip, st, bl, rt, fl;
  logic e_st, e_bl, e_rt, e_fl;
  logic [2:0] e_sts;
  logic [3:0] lat = 4'h0;
  bf_status_t sts;
  currents_t cur = '0;
  op_mode_t mode = MODE_CURRENT;
  int n_fail = 0, total_checks = 0, seed = 92, cnt = 0;
  int thr[4] = '{1000, 1000, 1000, 500};
  bit pu[4];
  always #10 clk = ~clk;
  breaker_failure_timer_logic i_breaker_failure_timer_logic (
    .core_clk_i(clk), .resetn_i(rstn), .clk_en_i(en), .cycle_tick_i(tick),
    .currents_i(cur), .phase_pickup_threshold_i(16'h03e8),
    .residual_pickup_threshold_i(16'h01f4), .residual_enable_i(1'b1),
    .primary_trip_i(trip), .block_i(blk), .mode_i(mode),
    .retrip_enable_i(rte), .redundant_trip_delay_i(RETRIP_STEPS_RST),
    .fail_delay_i(FAIL_STEPS_RST), .start_o(st), .blocked_o(bl),
    .redundant_trip_o(rt), .breaker_failure_trip_o(fl), .status_o(sts));
  bf_partner i_bf_partner (.clk_i(clk), .resetn_i(rstn), .tick_i(tick),
    .fault_i(flt), .lat_i(lat), .trip_o(trip));
  // Reference evaluation of one program cycle
  task automatic model();
    bit c, pk, tm;
    int m;
    c = 1'b0;
    for (int i = 0; i < 4; i++) begin
      m = cur[16*(3-i) +: 16];
      pu[i] = pu[i] ? (m * 100 > thr[i] * 97) : (m > thr[i]);
      c |= pu[i];
    end
    pk = (mode == MODE_CONTACT) ? trip :
      (mode == MODE_CUR_OR_CONTACT) ? c | trip : c;
    tm = pk && (mode != MODE_CUR_AND_CONTACT || trip);
    e_bl = pk & blk;
    e_st = pk & !blk;
    cnt = (tm && !blk) ? cnt + 1 : 0;
    e_rt = rte && cnt > 0 && cnt >= int'(RETRIP_STEPS_RST);
    e_fl = cnt > 0 && cnt >= int'(FAIL_STEPS_RST);
    e_sts = e_bl ? 3'h4 : e_fl ? 3'h3 : e_rt ? 3'h2 : {2'h0, e_st};
  endtask : model
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // Segments: mode, level percent, block, fault, retrip, channel
  initial begin
    static int sg[11][6] = '{'{0, 150, 0, 0, 1, 0}, '{0, 98, 0, 0, 1, 0},
      '{0, 0, 0, 0, 1, 0}, '{0, 150, 0, 0, 1, 3}, '{0, 150, 1, 0, 1, 1},
      '{1, 150, 0, 0, 1, 2}, '{1, 150, 0, 1, 1, 2}, '{2, 0, 0, 1, 1, 0},
      '{2, 0, 0, 0, 1, 0}, '{3, 0, 0, 1, 0, 0}, '{0, 98, 0, 0, 1, 0}};
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    foreach (sg[s]) begin
      mode = op_mode_t'(sg[s][0]);
      blk = sg[s][2][0];
      flt = sg[s][3][0];
      rte = sg[s][4][0];
      lat = 4'(s);
      repeat (100) begin
        cur = '0;
        if (sg[s][1] != 0)
          cur[16*(3-sg[s][5]) +: 16] =
            16'(thr[sg[s][5]] * sg[s][1] / 100 + ($random(seed) & 3));
        tick = ($random(seed) & 3) != 0;
        en = ($random(seed) & 15) != 0;
        if (en && tick) model();
        @(posedge clk);
        #1;
        `CHK("start", e_st, st)
        `CHK("blocked", e_bl, bl)
        `CHK("retrip", e_rt, rt)
        `CHK("failure", e_fl, fl)
        `CHK("status", e_sts, sts)
      end
    end
    conclude();
  end
endmodule : breaker_failure_timer_logic_test
`default_nettype wire

// ===== rtl/bf_timer_pkg.sv
// Constants, types and mode codes for the breaker failure supervision block.
// Assumes a 50 MHz core clock and a program-cycle tick from outside.
//
// Functional notes
// - Blocking sampled at start of each cycle.
// - Unblocked pick-up asserts start, runs timers.
// - Blocked pick-up flags blocked, no timing, no trips.
// - Blocking drops start like pick-up release.
// - Both timers start from one pick-up.
// - Retrip disabled means no retrip output ever.
// - Retrip after start lasts retrip delay.
// - Failure trip after start lasts failure delay.
// - Status: normal, start, retrip, failure, blocked.
// - Current mode times on phase or residual current.
// - Current mode ignores contact, clears on current drop.
// - Current-and-contact holds timers until contact active.
// - Current-and-contact clears on either signal dropping.
// - Current-and-contact trips only with both present.
// - Current-or-contact times on either signal.
// - Current-or-contact clears only when both gone.
// - Any phase above common threshold picks up.
// - Release at 97 percent of threshold.
// - Mode selector chooses pick-up criteria.
`default_nettype none

package bf_timer_pkg;

  localparam int CUR_W = 16;
  localparam int CNT_W = 20;
  localparam int STEP_W = 19;

  // Delays in milliseconds and the program cycle they are counted in
  localparam int CYCLE_MS = 5;
  localparam int DELAY_STEP_MS = 5;
  localparam int RETRIP_DELAY_MS = 100;
  localparam int FAIL_DELAY_MS = 200;
  localparam int BLOCK_LEAD_MS = 5;

  // Reset values of the delay settings, in program cycles
  localparam logic [STEP_W-1:0] RETRIP_STEPS_RST =
    STEP_W'(RETRIP_DELAY_MS / CYCLE_MS);
  localparam logic [STEP_W-1:0] FAIL_STEPS_RST =
    STEP_W'(FAIL_DELAY_MS / CYCLE_MS);

  // Release ratio 97/100
  localparam int RESET_NUM = 97;
  localparam int RESET_DEN = 100;

  typedef enum logic [1:0] {
    MODE_CURRENT,
    MODE_CUR_AND_CONTACT,
    MODE_CUR_OR_CONTACT,
    MODE_CONTACT
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_START,
    ST_RETRIP,
    ST_FAIL_ON,
    ST_BLOCKED
  } bf_status_t;

  typedef struct packed {
    logic [CUR_W-1:0] phase_a;
    logic [CUR_W-1:0] phase_b;
    logic [CUR_W-1:0] phase_c;
    logic [CUR_W-1:0] residual;
  } currents_t;

  typedef struct packed {
    logic [2:0] phase_pu;
    logic residual_pu;
    logic block;
    logic pickup;
    logic start;
    logic blocked;
    logic [CNT_W-1:0] cnt;
    logic retrip;
    logic fail;
    bf_status_t status;
  } bf_state_t;

endpackage : bf_timer_pkg

`default_nettype wire

// ===== rtl/breaker_failure_timer_logic.sv
// Breaker failure supervision: pick-up, blocking, two delay timers.
// Assumes currents, thresholds and contact are sampled in the core domain
// and a one-cycle cycle_tick_i marks each program cycle.
// Outputs are registered and move only on an evaluated program cycle.
`default_nettype none

// Level compare of one measured current with release hysteresis.
// Combinational; the caller keeps the previous result as state.
module pickup_cmp
  import bf_timer_pkg::*;
#(
  parameter int WIDTH = CUR_W,
  parameter int NUM = RESET_NUM,
  parameter int DEN = RESET_DEN
) (
  input wire logic [WIDTH-1:0] meas_i,
  input wire logic [WIDTH-1:0] thr_i,
  input wire logic was_on_i,
  input wire logic in_use_i,
  output logic pickup_o
);

  // Eight spare bits hold a ratio term of up to 255
  localparam int PROD_W = WIDTH + 8;

  // Refuse widths and ratios the products cannot carry
  if (WIDTH < 1) begin : g_chk_width
    $error("pickup_cmp WIDTH must be positive");
  end
  if (DEN < 1 || DEN > 255) begin : g_chk_den
    $error("pickup_cmp DEN must lie in 1 to 255");
  end
  if (NUM < 1 || NUM > DEN) begin : g_chk_num
    $error("pickup_cmp NUM must lie in 1 to DEN");
  end

  logic [PROD_W-1:0] meas_scaled;
  logic [PROD_W-1:0] thr_scaled;
  logic above_set;
  logic above_release;

  // Both sides scaled so the release ratio stays in integers
  assign meas_scaled = PROD_W'(meas_i) * PROD_W'(DEN);
  assign thr_scaled = PROD_W'(thr_i) * PROD_W'(NUM);

  // Strictly above the level to pick up
  assign above_set = (meas_i > thr_i);

  // Held until the level falls to the release ratio
  assign above_release = (meas_scaled > thr_scaled);

  // Channel out of use never picks up
  assign pickup_o = in_use_i && (was_on_i ? above_release : above_set);

endmodule : pickup_cmp

// Delay compare of the shared count against one setting.
// Combinational; an idle timer never reaches its delay.
module delay_reach
  import bf_timer_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W,
  parameter int SET_WIDTH = STEP_W
) (
  input wire logic run_i,
  input wire logic enable_i,
  input wire logic [CNT_WIDTH-1:0] count_i,
  input wire logic [SET_WIDTH-1:0] delay_i,
  output logic reached_o
);

  // The setting must fit the counter
  if (SET_WIDTH > CNT_WIDTH) begin : g_chk_width
    $error("delay_reach setting wider than counter");
  end
  if (CNT_WIDTH < 1) begin : g_chk_cnt
    $error("delay_reach counter width must be positive");
  end

  logic [CNT_WIDTH-1:0] limit;

  // Setting widened to the counter
  assign limit = CNT_WIDTH'(delay_i);

  // Reached once the count of this cycle meets the setting
  assign reached_o = run_i && enable_i && (count_i >= limit);

endmodule : delay_reach

// Pick-up, blocking and the two trip timers of one breaker.
// All evaluation waits for the program-cycle tick.
module breaker_failure_timer_logic
  import bf_timer_pkg::*;
#(
  parameter int CUR_WIDTH = CUR_W
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic cycle_tick_i,
  input wire currents_t currents_i,
  input wire logic [CUR_W-1:0] phase_pickup_threshold_i,
  input wire logic [CUR_W-1:0] residual_pickup_threshold_i,
  input wire logic residual_enable_i,
  input wire logic primary_trip_i,
  input wire logic block_i,
  input wire op_mode_t mode_i,
  input wire logic retrip_enable_i,
  input wire logic [STEP_W-1:0] redundant_trip_delay_i,
  input wire logic [STEP_W-1:0] fail_delay_i,
  output logic start_o,
  output logic blocked_o,
  output logic redundant_trip_o,
  output logic breaker_failure_trip_o,
  output bf_status_t status_o
);

  // Channel order of the pick-up comparators, residual last
  localparam int CH_N = 4;
  localparam int CH_RES = 3;

  // Counter limits
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // Elaboration checks on what the logic can serve
  if (CUR_WIDTH != CUR_W) begin : g_chk
    $error("CUR_WIDTH must equal package CUR_W");
  end
  if (STEP_W > CNT_W) begin : g_chk_step
    $error("delay settings wider than the cycle counter");
  end
  if (CYCLE_MS < 1) begin : g_chk_tick
    $error("program cycle must be positive");
  end
  if (DELAY_STEP_MS != CYCLE_MS) begin : g_chk_cycle
    $error("delay step must equal one program cycle");
  end
  if (RESET_NUM >= RESET_DEN) begin : g_chk_ratio
    $error("release ratio must lie below one");
  end

  // Default delays keep the redundant trip first
  if (RETRIP_STEPS_RST >= FAIL_STEPS_RST) begin : g_chk_order
    $error("default redundant trip delay not below failure delay");
  end

  // Whole state of the block and its next value
  bf_state_t st_ff;
  bf_state_t nxt_st;

  // Per-channel operands of the comparators
  logic [CUR_W-1:0] ch_meas [CH_N];
  logic [CUR_W-1:0] ch_thr [CH_N];
  logic [CH_N-1:0] ch_was_on;
  logic [CH_N-1:0] ch_in_use;
  logic [CH_N-1:0] ch_pu;

  // Pick-up and timing terms of one program cycle
  logic cur_pu;
  logic contact;
  logic blk_now;
  logic pickup;
  logic timing;
  logic start_now;
  logic blocked_now;
  logic run;

  // Shared count and the two delay results
  logic [CNT_W-1:0] cnt_inc;
  logic retrip_hit;
  logic fail_hit;
  bf_status_t status_now;

  // Measured currents, phases first
  assign ch_meas[0] = currents_i.phase_a;
  assign ch_meas[1] = currents_i.phase_b;
  assign ch_meas[2] = currents_i.phase_c;
  assign ch_meas[CH_RES] = currents_i.residual;

  // One common level for all three phases
  assign ch_thr[0] = phase_pickup_threshold_i;
  assign ch_thr[1] = phase_pickup_threshold_i;
  assign ch_thr[2] = phase_pickup_threshold_i;
  assign ch_thr[CH_RES] = residual_pickup_threshold_i;

  // Previous result picks the set or the release level
  assign ch_was_on[2:0] = st_ff.phase_pu;
  assign ch_was_on[CH_RES] = st_ff.residual_pu;

  // Phases always in use, residual only when selected
  assign ch_in_use[2:0] = 3'h7;
  assign ch_in_use[CH_RES] = residual_enable_i;

  // One comparator per measured channel
  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    pickup_cmp #(
      .WIDTH(CUR_W),
      .NUM(RESET_NUM),
      .DEN(RESET_DEN)
    ) i_pickup_cmp (
      .meas_i(ch_meas[g]),
      .thr_i(ch_thr[g]),
      .was_on_i(ch_was_on[g]),
      .in_use_i(ch_in_use[g]),
      .pickup_o(ch_pu[g])
    );
  end

  // Any phase, one or more, or the residual channel
  assign cur_pu = (|ch_pu[2:0]) | ch_pu[CH_RES];

  // Contact and blocking as seen at this program cycle
  assign contact = primary_trip_i;
  assign blk_now = block_i;

  // Pick-up and timing criteria of the selected mode
  always_comb begin
    pickup = 1'b0;
    timing = 1'b0;
    case (mode_i)
      MODE_CURRENT: begin
        // Contact ignored, timing follows current alone
        pickup = cur_pu;
        timing = cur_pu;
      end
      MODE_CUR_AND_CONTACT: begin
        // Picked up on current, timed only with contact
        pickup = cur_pu;
        timing = cur_pu & contact;
      end
      MODE_CUR_OR_CONTACT: begin
        // Either criterion keeps pick-up and timing
        pickup = cur_pu | contact;
        timing = cur_pu | contact;
      end
      MODE_CONTACT: begin
        // Contact alone
        pickup = contact;
        timing = contact;
      end
      default: begin
        pickup = 1'b0;
        timing = 1'b0;
      end
    endcase
  end

  // Blocking decides between start and blocked
  assign start_now = pickup & ~blk_now;
  assign blocked_now = pickup & blk_now;

  // Both timers run from the one start condition
  assign run = start_now & timing;

  // Saturating step of the shared cycle counter
  assign cnt_inc = (st_ff.cnt == CNT_MAX) ? st_ff.cnt :
    st_ff.cnt + CNT_ONE;

  // Redundant trip only when enabled and its delay reached
  delay_reach #(
    .CNT_WIDTH(CNT_W),
    .SET_WIDTH(STEP_W)
  ) i_retrip_reach (
    .run_i(run),
    .enable_i(retrip_enable_i),
    .count_i(cnt_inc),
    .delay_i(redundant_trip_delay_i),
    .reached_o(retrip_hit)
  );

  // Failure trip once the longer delay is reached
  delay_reach #(
    .CNT_WIDTH(CNT_W),
    .SET_WIDTH(STEP_W)
  ) i_fail_reach (
    .run_i(run),
    .enable_i(1'b1),
    .count_i(cnt_inc),
    .delay_i(fail_delay_i),
    .reached_o(fail_hit)
  );

  // Status follows the highest active indication
  always_comb begin
    if (blocked_now) begin
      status_now = ST_BLOCKED;
    end else if (fail_hit) begin
      status_now = ST_FAIL_ON;
    end else if (retrip_hit) begin
      status_now = ST_RETRIP;
    end else if (start_now) begin
      status_now = ST_START;
    end else begin
      status_now = ST_NORMAL;
    end
  end

  // Next state, evaluated once per program cycle
  always_comb begin
    nxt_st = st_ff;
    if (cycle_tick_i) begin
      // Blocking sampled before pick-up acts
      nxt_st.block = blk_now;
      // Channel results kept for the release level
      nxt_st.phase_pu = ch_pu[2:0];
      nxt_st.residual_pu = ch_pu[CH_RES];
      nxt_st.pickup = pickup;
      // Start and blocked never both
      nxt_st.start = start_now;
      nxt_st.blocked = blocked_now;
      // Count while timing, cleared on any release
      if (run) begin
        nxt_st.cnt = cnt_inc;
      end else begin
        nxt_st.cnt = '0;
      end
      // Trips take the count of this cycle
      nxt_st.retrip = retrip_hit;
      nxt_st.fail = fail_hit;
      nxt_st.status = status_now;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
    end
  end

  // Indications straight from the state register
  assign start_o = st_ff.start;
  assign blocked_o = st_ff.blocked;

  // Trips and status straight from the state register
  assign redundant_trip_o = st_ff.retrip;
  assign breaker_failure_trip_o = st_ff.fail;
  assign status_o = st_ff.status;

endmodule : breaker_failure_timer_logic

`default_nettype wire
